// ### logic/system_bus_glue_control.sv
// Top level of the system bus glue block
`timescale 1ns/1ps
`default_nettype none
module system_bus_glue_control #(
  parameter int DIV_W = 4 // Width of the clock dividers
) (
  input wire logic clk_sys, // Processor double clock, 40 MHz
  input wire logic reset, // Synchronous reset, active high
  input wire logic hwResetIn, // Hardware reset from slot bus controller
  input wire logic [1:0] procCycle, // Decoded processor cycle, sys_glue_pkg::proc_cycle_t
  input wire logic procMemIo, // Processor memory (1) or I/O (0)
  input wire logic [15:0] procIoAddr, // Processor I/O address of current cycle
  input wire logic procCycleValid, // One-cycle pulse, cycle started
  input wire logic chanAccess, // Current cycle goes to the channel
  input wire logic onboardAddr, // Current address selects onboard DRAM
  input wire logic procAddr20, // Processor address bit 20
  output logic addr20Out, // Gated address bit 20
  input wire logic chanSelect0MemwriteIn, // Select0 pin level in
  input wire logic chanSelect1MemreadIn, // Select1 pin level in
  output logic chanSelect0MemwriteOut, // Select0 pin drive value
  output logic chanSelect1MemreadOut, // Select1 pin drive value
  output logic chanSelectOe, // Select pins output enable
  output logic chanMemOrIo, // Channel memory/io
  output logic blockAddrBit20N, // Block A20, active low
  input wire logic kbdAddrGateIn, // Keyboard A20 gate, async
  input wire logic slotBusOscIn, // External bus oscillator, async
  output logic slotBusSrcClk, // Slot bus source clock
  input wire logic dmaHoldReqIn, // DMA hold request, async
  output logic procHoldReq, // Hold request to processor
  input wire logic procHoldAckIn, // Processor hold acknowledge, async
  output logic dmaHoldAckOut, // DMA hold acknowledge
  output logic onboardDramSelN, // Board DRAM, active low
  input wire logic refreshReqIn, // Refresh request, async
  output logic refreshReqSeen, // Synchronised refresh request
  input wire logic kbdResetCtrlN, // Keyboard reset control, async
  output logic procResetOut, // Processor reset
  input wire logic turboIn, // Turbo input, async
  output logic slowStrobe, // Slow-mode processor clock qualifier
  input wire logic sleepMode, // Sleep mode active
  output logic [2:0] sleepOut, // Sleep pins output value (always low)
  output logic [2:0] sleepOe, // Sleep pins output enable
  output logic dataBufEnableN, // Data buffer enable, active low
  input wire logic ioReadN, // Slot I/O read strobe, active low
  input wire logic ioWriteN, // Slot I/O write strobe, active low
  input wire logic [3:0] bankColStrobe, // Bank column strobes
  output logic memDataLatchN, // Memory data latch, active low
  output logic memReadOut, // Onboard memory read control
  output logic memWriteOut, // Onboard memory write control
  input wire logic [31:0] s_axi_awaddr, // AXI write address
  input wire logic s_axi_awvalid, // AXI write address valid
  output logic s_axi_awready, // AXI write address ready
  input wire logic [31:0] s_axi_wdata, // AXI write data
  input wire logic [3:0] s_axi_wstrb, // AXI write strobes
  input wire logic s_axi_wvalid, // AXI write data valid
  output logic s_axi_wready, // AXI write data ready
  output logic [1:0] s_axi_bresp, // AXI write response
  output logic s_axi_bvalid, // AXI write response valid
  input wire logic s_axi_bready, // AXI write response ready
  input wire logic [31:0] s_axi_araddr, // AXI read address
  input wire logic s_axi_arvalid, // AXI read address valid
  output logic s_axi_arready, // AXI read address ready
  output logic [31:0] s_axi_rdata, // AXI read data
  output logic [1:0] s_axi_rresp, // AXI read response
  output logic s_axi_rvalid, // AXI read valid
  input wire logic s_axi_rready // AXI read ready
);
  import sys_glue_pkg::*;

  // Byte-lane merge, used by every writable register
  function automatic logic [31:0] mergeLanes(input logic [31:0] old, input logic [31:0] wd,
                                             input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (st[i])
      begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Combined reset, hardware reset acts like local reset
  logic rstAll;
  assign rstAll = reset | hwResetIn;

  // Two-stage synchronisers: gate, turbo, refresh, kbd reset, dma req, hold ack, osc
  logic [6:0] asyncIn;
  logic [6:0] sync1_q, sync1_d, sync2_q, sync2_d;
  assign asyncIn = {slotBusOscIn, procHoldAckIn, dmaHoldReqIn, kbdResetCtrlN, refreshReqIn, turboIn, kbdAddrGateIn};
  // Synchroniser next values
  always_comb
  begin
    sync1_d = asyncIn;
    sync2_d = sync1_q;
  end
  // two-stage synchroniser
  // Idle levels loaded on reset, reset control idles high
  always_ff @(posedge clk_sys)
  begin
    if (rstAll)
    begin
      sync1_q <= 7'h08;
      sync2_q <= 7'h08;
    end
    else
    begin
      sync1_q <= sync1_d;
      sync2_q <= sync2_d;
    end
  end
  logic gateS, turboS, refreshS, kbdRstNS, dmaReqS, holdAckS, oscS;
  assign {oscS, holdAckS, dmaReqS, kbdRstNS, refreshS, turboS, gateS} = sync2_q;

  // Software registers
  logic [31:0] portCtrl_q, portCtrl_d; // Reset and A20 enable bits
  logic [31:0] miscSetup_q, miscSetup_d; // Divisors, turbo latch, async mode
  logic [31:0] sleepCfg_q, sleepCfg_d; // Sleep pin enables
  // AXI write channel state
  logic awHeld_q, awHeld_d, wHeld_q, wHeld_d, bValid_q, bValid_d;
  logic [7:0] awAddr_q, awAddr_d;
  logic [31:0] wData_q, wData_d;
  logic [3:0] wStrb_q, wStrb_d;
  logic [1:0] bResp_q, bResp_d;
  // AXI read channel state
  logic rValid_q, rValid_d;
  logic [31:0] rData_q, rData_d;
  logic [1:0] rResp_q, rResp_d;
  // Dummy-read detector for port set
  logic ioEeRead;
  assign ioEeRead = procCycleValid && !procMemIo && procCycle == PC_READ && procIoAddr == IO_PORT_A20_SET;

  // Register file and AXI slave next state
  always_comb
  begin
    portCtrl_d = portCtrl_q;
    miscSetup_d = miscSetup_q;
    sleepCfg_d = sleepCfg_q;
    awHeld_d = awHeld_q;
    wHeld_d = wHeld_q;
    awAddr_d = awAddr_q;
    wData_d = wData_q;
    wStrb_d = wStrb_q;
    bValid_d = bValid_q;
    bResp_d = bResp_q;
    rValid_d = rValid_q;
    rData_d = rData_q;
    rResp_d = rResp_q;
    // Address and data accepted in any order
    if (s_axi_awvalid && s_axi_awready)
    begin
      awHeld_d = 1'b1;
      awAddr_d = s_axi_awaddr[7:0];
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      wHeld_d = 1'b1;
      wData_d = s_axi_wdata;
      wStrb_d = s_axi_wstrb;
    end
    // Perform write once both halves are held
    if (awHeld_q && wHeld_q && !bValid_q)
    begin
      awHeld_d = 1'b0;
      wHeld_d = 1'b0;
      bValid_d = 1'b1;
      bResp_d = RESP_OKAY;
      unique case (awAddr_q)
        OFF_PORT_CTRL: portCtrl_d = mergeLanes(portCtrl_q, wData_q, wStrb_q) & 32'h0000_0003;
        OFF_MISC_SETUP: miscSetup_d = mergeLanes(miscSetup_q, wData_q, wStrb_q) & 32'h0000_0f3f;
        OFF_SLEEP_CFG: sleepCfg_d = mergeLanes(sleepCfg_q, wData_q, wStrb_q) & 32'h0000_008e;
        OFF_STATUS: bResp_d = RESP_SLVERR;
        default: bResp_d = RESP_SLVERR;
      endcase
    end
    if (bValid_q && s_axi_bready)
    begin
      bValid_d = 1'b0;
    end
    // Hardware set after software write, so the set wins
    if (ioEeRead)
    begin
      portCtrl_d[BIT_A20_EN] = 1'b1;
    end
    // Read channel, one cycle after address accepted
    if (s_axi_arvalid && s_axi_arready)
    begin
      rValid_d = 1'b1;
      rResp_d = RESP_OKAY;
      unique case (s_axi_araddr[7:0])
        OFF_PORT_CTRL: rData_d = portCtrl_q;
        OFF_MISC_SETUP: rData_d = miscSetup_q;
        OFF_SLEEP_CFG: rData_d = sleepCfg_q;
        OFF_STATUS: rData_d = {24'h00_0000, slowStrobe, turboS, refreshS, holdAckS,
                               procHoldReq, procResetOut, blockAddrBit20N, gateS};
        default:
        begin
          rData_d = 32'h0000_0000;
          rResp_d = RESP_SLVERR;
        end
      endcase
    end
    else if (rValid_q && s_axi_rready)
    begin
      rValid_d = 1'b0;
    end
  end
  // Register file and AXI slave flops
  always_ff @(posedge clk_sys)
  begin
    if (rstAll)
    begin
      portCtrl_q <= RST_PORT_CTRL;
      miscSetup_q <= RST_MISC_SETUP;
      sleepCfg_q <= RST_SLEEP_CFG;
      awHeld_q <= 1'b0;
      wHeld_q <= 1'b0;
      awAddr_q <= 8'h00;
      wData_q <= 32'h0000_0000;
      wStrb_q <= 4'h0;
      bValid_q <= 1'b0;
      bResp_q <= RESP_OKAY;
      rValid_q <= 1'b0;
      rData_q <= 32'h0000_0000;
      rResp_q <= RESP_OKAY;
    end
    else
    begin
      portCtrl_q <= portCtrl_d;
      miscSetup_q <= miscSetup_d;
      sleepCfg_q <= sleepCfg_d;
      awHeld_q <= awHeld_d;
      wHeld_q <= wHeld_d;
      awAddr_q <= awAddr_d;
      wData_q <= wData_d;
      wStrb_q <= wStrb_d;
      bValid_q <= bValid_d;
      bResp_q <= bResp_d;
      rValid_q <= rValid_d;
      rData_q <= rData_d;
      rResp_q <= rResp_d;
    end
  end
  // Ready while the slot for that half is empty
  assign s_axi_awready = !awHeld_q && !rstAll;
  assign s_axi_wready = !wHeld_q && !rstAll;
  assign s_axi_bvalid = bValid_q;
  assign s_axi_bresp = bResp_q;
  assign s_axi_arready = !rValid_q && !rstAll;
  assign s_axi_rvalid = rValid_q;
  assign s_axi_rdata = rData_q;
  assign s_axi_rresp = rResp_q;

  // Dividers: slow-speed strobe and slot source clock
  logic [DIV_W-1:0] slowCnt_q, slowCnt_d, busCnt_q, busCnt_d;
  logic slowStrobe_q, slowStrobe_d, slot_bus_src_clk_q, slot_bus_src_clk_d, oscPrev_q, oscPrev_d;
  logic turboOk;
  assign turboOk = turboS & miscSetup_q[BIT_TURBO_LATCH];
  // Divider next state
  always_comb
  begin
    logic [DIV_W-1:0] slowDiv;
    logic [DIV_W-1:0] busDiv;
    logic tick;
    slowDiv = DIV_W'(miscSetup_q[MS_DIV_LSB +: MS_DIV_W]);
    busDiv = DIV_W'(miscSetup_q[MS_BDIV_LSB +: MS_BDIV_W]);
    // selectable bus clock source
    // Oscillator is sampled, so async mode is limited to below clk_sys/2
    tick = miscSetup_q[BIT_ASYNC_BUS] ? (oscS & ~oscPrev_q) : 1'b1;
    oscPrev_d = oscS;
    // divisor up to 16
    // Divide by field+1; 40 MHz / 16 is well below 8 MHz
    slowCnt_d = slowCnt_q + 1'b1;
    slowStrobe_d = 1'b0;
    if (turboOk)
    begin
      slowCnt_d = '0;
      slowStrobe_d = 1'b1;
    end
    else if (slowCnt_q >= slowDiv)
    begin
      slowCnt_d = '0;
      slowStrobe_d = 1'b1;
    end
    busCnt_d = busCnt_q;
    slot_bus_src_clk_d = slot_bus_src_clk_q;
    if (tick)
    begin
      if (busCnt_q >= busDiv)
      begin
        busCnt_d = '0;
        slot_bus_src_clk_d = ~slot_bus_src_clk_q;
      end
      else
      begin
        busCnt_d = busCnt_q + 1'b1;
      end
    end
  end
  // Divider flops
  always_ff @(posedge clk_sys)
  begin
    if (rstAll)
    begin
      slowCnt_q <= '0;
      busCnt_q <= '0;
      slowStrobe_q <= 1'b1;
      slot_bus_src_clk_q <= 1'b0;
      oscPrev_q <= 1'b0;
    end
    else
    begin
      slowCnt_q <= slowCnt_d;
      busCnt_q <= busCnt_d;
      slowStrobe_q <= slowStrobe_d;
      slot_bus_src_clk_q <= slot_bus_src_clk_d;
      oscPrev_q <= oscPrev_d;
    end
  end
  assign slowStrobe = slowStrobe_q;
  assign slotBusSrcClk = slot_bus_src_clk_q;

  // Hold, reset and A20 output flops
  logic holdReq_q, holdReq_d, dmaAck_q, dmaAck_d, kbdPrev_q, kbdPrev_d, rstPulse_q, rstPulse_d;
  logic block_addr_bit20_n_q, block_addr_bit20_n_d, resetOut_q, resetOut_d;
  // Hold and reset next state
  always_comb
  begin
    holdReq_d = dmaReqS;
    dmaAck_d = holdAckS & dmaReqS;
    kbdPrev_d = kbdRstNS;
    rstPulse_d = kbdPrev_q & ~kbdRstNS;
    resetOut_d = ~kbdRstNS | portCtrl_q[BIT_SW_RESET] | rstPulse_q;
    block_addr_bit20_n_d = holdAckS | gateS | portCtrl_q[BIT_A20_EN];
  end
  // Hold and reset flops
  always_ff @(posedge clk_sys)
  begin
    if (rstAll)
    begin
      holdReq_q <= 1'b0;
      dmaAck_q <= 1'b0;
      kbdPrev_q <= 1'b1;
      rstPulse_q <= 1'b0;
      block_addr_bit20_n_q <= 1'b0;
      resetOut_q <= 1'b0;
    end
    else
    begin
      holdReq_q <= holdReq_d;
      dmaAck_q <= dmaAck_d;
      kbdPrev_q <= kbdPrev_d;
      rstPulse_q <= rstPulse_d;
      block_addr_bit20_n_q <= block_addr_bit20_n_d;
      resetOut_q <= resetOut_d;
    end
  end
  assign procHoldReq = holdReq_q;
  assign dmaHoldAckOut = dmaAck_q;
  assign blockAddrBit20N = block_addr_bit20_n_q;
  assign procResetOut = resetOut_q | hwResetIn;
  assign addr20Out = procAddr20 & (gateS | portCtrl_q[BIT_A20_EN]);
  assign refreshReqSeen = refreshS;

  // Channel cycle encoding and memory control, combinational decode
  logic ioCycle;
  assign ioCycle = !ioReadN || !ioWriteN;
  always_comb
  begin
    logic [1:0] enc;
    enc = CYC_IDLE;
    unique case (proc_cycle_t'(procCycle))
      PC_IDLE: enc = CYC_IDLE;
      PC_READ: enc = CYC_READ;
      PC_WRITE: enc = CYC_WRITE;
      PC_INT_ACK_CYCLE: enc = CYC_INT_ACK_CYCLE;
    endcase
    if (!chanAccess)
    begin
      enc = CYC_IDLE;
    end
    chanSelect1MemreadOut = enc[1];
    chanSelect0MemwriteOut = enc[0];
    chanSelectOe = !holdAckS;
    chanMemOrIo = procMemIo & chanAccess & !holdAckS;
    if (holdAckS)
    begin
      memReadOut = !chanSelect1MemreadIn && !ioCycle;
      memWriteOut = !chanSelect0MemwriteIn && !ioCycle;
    end
    else
    begin
      memReadOut = procMemIo && procCycle == PC_READ && onboardAddr && !ioCycle;
      memWriteOut = procMemIo && procCycle == PC_WRITE && onboardAddr && !ioCycle;
    end
    onboardDramSelN = !(onboardAddr && !ioCycle);
    dataBufEnableN = !(!holdAckS && (procCycle == PC_READ || procCycle == PC_INT_ACK_CYCLE));
    memDataLatchN = !(|bankColStrobe) || ioCycle;
  end

  // Sleep pins, open drain
  logic [2:0] sleepAct;
  assign sleepAct = sleepCfg_q[3:1] | {3{sleepCfg_q[BIT_SLEEP_EXT] | sleepMode}};
  assign sleepOe = ~sleepAct;
  assign sleepOut = 3'h0;
endmodule
`default_nettype wire

// ### logic/sys_glue_pkg.sv
// Constants, register map and types of the system bus glue block
package sys_glue_pkg;
  // Register byte offsets on the AXI4-Lite slave
  localparam logic [7:0] OFF_PORT_CTRL = 8'h00;
  localparam logic [7:0] OFF_MISC_SETUP = 8'h04;
  localparam logic [7:0] OFF_SLEEP_CFG = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0c;
  // Port control fields
  localparam int BIT_SW_RESET = 0;
  localparam int BIT_A20_EN = 1;
  // Misc setup fields
  localparam int MS_DIV_LSB = 0;
  localparam int MS_DIV_W = 4;
  localparam int BIT_TURBO_LATCH = 4;
  localparam int BIT_ASYNC_BUS = 5;
  localparam int MS_BDIV_LSB = 8;
  localparam int MS_BDIV_W = 4;
  // Sleep config fields
  localparam int BIT_SLEEP_EXT = 7;
  // Reset values
  localparam logic [31:0] RST_PORT_CTRL = 32'h0000_0000;
  localparam logic [31:0] RST_MISC_SETUP = 32'h0000_0110;
  localparam logic [31:0] RST_SLEEP_CFG = 32'h0000_0000;
  // Dummy read port that sets the A20 enable bit
  localparam logic [15:0] IO_PORT_A20_SET = 16'h00ee;
  // Slot bus controller cycle encoding on select1, select0
  localparam logic [1:0] CYC_IDLE = 2'h3;
  localparam logic [1:0] CYC_WRITE = 2'h2;
  localparam logic [1:0] CYC_READ = 2'h1;
  localparam logic [1:0] CYC_INT_ACK_CYCLE = 2'h0;
  // Processor cycle status
  typedef enum logic [1:0] {
    PC_IDLE = 2'b00,
    PC_READ = 2'b01,
    PC_WRITE = 2'b10,
    PC_INT_ACK_CYCLE = 2'b11
  } proc_cycle_t;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ### verif/system_bus_glue_control_assertions.sv
// Concurrent checks on the glue block ports
`timescale 1ns/1ps
`default_nettype none
module system_bus_glue_control_assertions #(
  parameter int DIV_W = 4 // Divider width, unused here
) (
  input wire logic clk_sys, // Clock
  input wire logic reset, // Sync reset
  input wire logic hwResetIn, // Hardware reset
  input wire logic [1:0] procCycle, // Cycle status
  input wire logic chanAccess, // Channel cycle
  input wire logic chanSelect0MemwriteOut, // Select0 drive
  input wire logic chanSelect1MemreadOut, // Select1 drive
  input wire logic chanSelectOe, // Select enable
  input wire logic procHoldAckIn, // Hold ack
  input wire logic blockAddrBit20N, // Block A20
  input wire logic dmaHoldReqIn, // DMA request
  input wire logic procHoldReq, // Hold request
  input wire logic dmaHoldAckOut, // DMA ack
  input wire logic onboardAddr, // Onboard hit
  input wire logic onboardDramSelN, // Board DRAM
  input wire logic ioReadN, // I/O read
  input wire logic ioWriteN, // I/O write
  input wire logic memReadOut, // Mem read
  input wire logic memWriteOut, // Mem write
  input wire logic kbdResetCtrlN, // Reset control
  input wire logic procResetOut, // Processor reset
  input wire logic sleepMode, // Sleep mode
  input wire logic [2:0] sleepOe, // Sleep enables
  input wire logic [2:0] sleepOut, // Sleep values
  input wire logic dataBufEnableN, // Data enable
  input wire logic [3:0] bankColStrobe, // Column strobes
  input wire logic memDataLatchN // Data latch
);
  import sys_glue_pkg::*;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);
  // Long enough for the synchroniser and output flop
  sequence holdOn;
    (procHoldAckIn && !hwResetIn)[*5];
  endsequence
  sequence reqOn;
    (dmaHoldReqIn && !hwResetIn)[*5];
  endsequence
  a_sel_write:
    assert property (chanSelectOe && chanAccess && procCycle == PC_WRITE
      |-> {chanSelect1MemreadOut, chanSelect0MemwriteOut} == CYC_WRITE) else $error("select code wrong");
  a_hold_turn:
    assert property (holdOn |-> !chanSelectOe && blockAddrBit20N) else $error("hold not honoured");
  a_hold_req:
    assert property (reqOn |-> procHoldReq) else $error("hold request missing");
  a_dma_ack:
    assert property (reqOn and holdOn |-> dmaHoldAckOut) else $error("dma ack missing");
  a_board_dram:
    assert property (onboardAddr && ioReadN && ioWriteN |-> !onboardDramSelN) else $error("board dram high");
  a_io_quiet:
    assert property (!(ioReadN && ioWriteN) |-> onboardDramSelN && !memReadOut && !memWriteOut)
      else $error("memory active in io cycle");
  a_rc_fall:
    assert property ($fell(kbdResetCtrlN) && !hwResetIn |-> ##[1:6] procResetOut) else $error("no cpu reset");
  a_hw_reset:
    assert property (hwResetIn |-> procResetOut) else $error("hw reset not passed");
  a_sleep_rel:
    assert property (sleepMode[*2] |-> sleepOe == 3'h0 && sleepOut == 3'h0) else $error("sleep pin driven");
  a_den_read:
    assert property (procCycle[0] && chanSelectOe |-> !dataBufEnableN) else $error("data enable high");
  a_latch_cas:
    assert property (|bankColStrobe |-> !memDataLatchN) else $error("latch high with strobe");
endmodule
bind system_bus_glue_control system_bus_glue_control_assertions #(.DIV_W(DIV_W)) i_chk (.*);
`default_nettype wire

// ### verif/slot_bus_ctrl_model.sv
// Behavioural slot bus controller facing the glue block
`timescale 1ns/1ps
`default_nettype none
module slot_bus_ctrl_model (
  input wire logic clk_sys, // Clock
  input wire logic selOe, // Block drives selects
  input wire logic sel0Out, // Block select0 value
  input wire logic sel1Out, // Block select1 value
  input wire logic wantDma, // Bench asks for DMA
  input wire logic wantRefresh, // Bench asks refresh
  input wire logic wantWrite, // Memory write strobe
  input wire logic wantRead, // Memory read strobe
  output logic dmaHoldReqIn, // DMA hold request
  output logic refreshReqIn, // Refresh request
  output logic sel0Pin, // Select0 wire level
  output logic sel1Pin // Select1 wire level
);
  // refresh on input
  // Requests launched from our own flop, as a real controller would
  always_ff @(posedge clk_sys)
  begin
    dmaHoldReqIn <= wantDma;
    refreshReqIn <= wantRefresh;
  end
  // strobes during hold
  // Wire level: block drives, else we drive active-low strobes
  assign sel0Pin = selOe ? sel0Out : !wantWrite;
  assign sel1Pin = selOe ? sel1Out : !wantRead;
endmodule
`default_nettype wire

// ### verif/system_bus_glue_control_tb_top.sv
// Self-checking bench of the glue block
`timescale 1ns/1ps
`default_nettype none
module system_bus_glue_control_tb_top;
  import sys_glue_pkg::*;
  logic clk_sys, reset, hwResetIn, procMemIo, procCycleValid, chanAccess, onboardAddr, procAddr20;
  logic [1:0] procCycle;
  logic [15:0] procIoAddr;
  logic kbdAddrGateIn, slotBusOscIn, procHoldAckIn, kbdResetCtrlN, turboIn, sleepMode, ioReadN, ioWriteN;
  logic [3:0] bankColStrobe, s_axi_wstrb;
  logic chanSelect0MemwriteIn, chanSelect1MemreadIn, dmaHoldReqIn, refreshReqIn;
  logic addr20Out, chanSelect0MemwriteOut, chanSelect1MemreadOut, chanSelectOe, chanMemOrIo, blockAddrBit20N;
  logic slotBusSrcClk, procHoldReq, dmaHoldAckOut, onboardDramSelN, refreshReqSeen, procResetOut, slowStrobe;
  logic dataBufEnableN, memDataLatchN, memReadOut, memWriteOut;
  logic [2:0] sleepOut, sleepOe;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic wantDma, wantRefresh, wantWrite, wantRead; // Partner commands
  logic [1:0] enc [4]; // Expected select codes
  int mismatches, n_checks, sc, tc; // Counters and counts
  system_bus_glue_control i_system_bus_glue_control (.*);
  slot_bus_ctrl_model i_slot_bus_ctrl_model (.clk_sys(clk_sys), .selOe(chanSelectOe),
    .sel0Out(chanSelect0MemwriteOut), .sel1Out(chanSelect1MemreadOut), .wantDma(wantDma),
    .wantRefresh(wantRefresh), .wantWrite(wantWrite), .wantRead(wantRead), .dmaHoldReqIn(dmaHoldReqIn),
    .refreshReqIn(refreshReqIn), .sel0Pin(chanSelect0MemwriteIn), .sel1Pin(chanSelect1MemreadIn));
  // 40 MHz clock
  initial
  begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  // Slot oscillator
  always @(posedge clk_sys) slotBusOscIn <= !slotBusOscIn || reset;
  // Verdict and end of run
  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Compare seen against expected
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Wait n edges, then settle
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  // Bounded wait guard; a hang ends the run
  task automatic guard(inout int g);
    g++;
    if (g > 1000)
    begin
      mismatches++;
      tally_and_finish();
    end
  endtask
  // AXI4-Lite write, response compared
  task automatic axiWr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    bit pa, pw, ta, tw, tb;
    int g;
    logic [1:0] r;
    pa = 1; pw = 1; g = 0;
    @(posedge clk_sys);
    s_axi_awaddr <= {24'h0, a}; s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1; s_axi_bready <= 1'b1;
    while (pa || pw)
    begin
      #1;
      ta = pa && s_axi_awready; tw = pw && s_axi_wready;
      @(posedge clk_sys);
      if (ta) begin s_axi_awvalid <= 1'b0; pa = 0; end
      if (tw) begin s_axi_wvalid <= 1'b0; pw = 0; end
      guard(g);
    end
    do
    begin
      #1;
      tb = s_axi_bvalid; r = s_axi_bresp;
      @(posedge clk_sys);
      guard(g);
    end while (!tb);
    s_axi_bready <= 1'b0;
    chk(r, er);
  endtask
  // AXI4-Lite read, data and response compared
  task automatic axiRd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    bit ta, tr;
    int g;
    g = 0;
    @(posedge clk_sys);
    s_axi_araddr <= {24'h0, a}; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
    do
    begin
      #1;
      ta = s_axi_arready;
      @(posedge clk_sys);
      guard(g);
    end while (!ta);
    s_axi_arvalid <= 1'b0;
    do
    begin
      #1;
      tr = s_axi_rvalid;
      if (tr) chk(s_axi_rdata, ed);
      if (tr) chk(s_axi_rresp, er);
      @(posedge clk_sys);
      guard(g);
    end while (!tr);
    s_axi_rready <= 1'b0;
  endtask
  // Count slow strobes and source clock toggles over n cycles
  task automatic cnt(input int n);
    logic p;
    sc = 0; tc = 0; p = slotBusSrcClk;
    repeat (n)
    begin
      cyc(1);
      sc += int'(slowStrobe === 1'b1);
      tc += int'(slotBusSrcClk !== p);
      p = slotBusSrcClk;
    end
  endtask
  // Main sequence
  initial
  begin
    enc = '{CYC_IDLE, CYC_READ, CYC_WRITE, CYC_INT_ACK_CYCLE};
    {hwResetIn, procMemIo, procCycleValid, chanAccess, onboardAddr, kbdAddrGateIn} = '0;
    {procHoldAckIn, turboIn, sleepMode, wantDma, wantRefresh, wantWrite, wantRead} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {procCycle, procIoAddr, bankColStrobe, s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
    {procAddr20, kbdResetCtrlN, ioReadN, ioWriteN} = 4'hf;
    s_axi_wstrb = 4'hf;
    mismatches = 0; n_checks = 0;
    reset = 1'b1;
    repeat (6) @(posedge clk_sys);
    reset <= 1'b0;
    axiRd(OFF_PORT_CTRL, RST_PORT_CTRL, RESP_OKAY);
    axiRd(OFF_MISC_SETUP, RST_MISC_SETUP, RESP_OKAY);
    axiRd(8'h10, 32'h0, RESP_SLVERR);
    axiWr(OFF_STATUS, 32'h1, RESP_SLVERR);
    // Cycle codes, memory/io, data enable
    @(posedge clk_sys) chanAccess <= 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clk_sys);
      procCycle <= i[1:0];
      procMemIo <= i[0];
      cyc(1);
      chk({chanSelect1MemreadOut, chanSelect0MemwriteOut}, enc[i]);
      chk(chanMemOrIo, i[0]);
      chk(dataBufEnableN, !i[0]);
    end
    // Address bit 20 gating
    cyc(1);
    chk({blockAddrBit20N, addr20Out}, 2'b00);
    @(posedge clk_sys) kbdAddrGateIn <= 1'b1;
    cyc(5);
    chk({blockAddrBit20N, addr20Out}, 2'b11);
    @(posedge clk_sys) kbdAddrGateIn <= 1'b0;
    axiWr(OFF_PORT_CTRL, 32'h2, RESP_OKAY);
    cyc(5);
    chk({blockAddrBit20N, addr20Out}, 2'b11);
    axiWr(OFF_PORT_CTRL, 32'h0, RESP_OKAY);
    @(posedge clk_sys);
    {procCycle, procMemIo, procIoAddr, procCycleValid} <= {PC_READ, 1'b0, IO_PORT_A20_SET, 1'b1};
    @(posedge clk_sys) {procCycle, procCycleValid} <= {PC_IDLE, 1'b0};
    axiRd(OFF_PORT_CTRL, 32'h2, RESP_OKAY);
    axiWr(OFF_PORT_CTRL, 32'h0, RESP_OKAY);
    // DMA hold, channel strobes take over
    @(posedge clk_sys) {wantDma, onboardAddr} <= 2'b11;
    cyc(5);
    chk(procHoldReq, 1'b1);
    @(posedge clk_sys) procHoldAckIn <= 1'b1;
    cyc(5);
    chk({chanSelectOe, dmaHoldAckOut, blockAddrBit20N}, 3'b011);
    @(posedge clk_sys) wantWrite <= 1'b1;
    cyc(1);
    chk({memWriteOut, memReadOut}, 2'b10);
    @(posedge clk_sys) {wantWrite, wantRead} <= 2'b01;
    cyc(1);
    chk({memWriteOut, memReadOut}, 2'b01);
    @(posedge clk_sys) {wantRead, wantDma, procHoldAckIn} <= '0;
    cyc(6);
    chk({chanSelectOe, procHoldReq}, 2'b10);
    // I/O strobes mask the board DRAM select
    for (int i = 0; i < 3; i++)
    begin
      @(posedge clk_sys) {ioReadN, ioWriteN} <= 2'(i + 1);
      cyc(1);
      chk(onboardDramSelN, i != 2);
    end
    // Column strobes hold the latch open
    for (int i = 0; i < 5; i++)
    begin
      @(posedge clk_sys) bankColStrobe <= 4'(5'h1 << i);
      cyc(1);
      chk(memDataLatchN, i == 4);
    end
    // Refresh request passes the synchroniser
    @(posedge clk_sys) wantRefresh <= 1'b1;
    cyc(5);
    chk(refreshReqSeen, 1'b1);
    // Sleep pins
    for (int i = 1; i < 5; i++)
    begin
      axiWr(OFF_SLEEP_CFG, (i == 4) ? 32'h80 : 32'h1 << i, RESP_OKAY);
      cyc(1);
      chk({sleepOut, sleepOe}, (i == 4) ? 6'h0 : 6'h7 ^ (6'h1 << (i - 1)));
    end
    axiWr(OFF_SLEEP_CFG, 32'h0, RESP_OKAY);
    @(posedge clk_sys) sleepMode <= 1'b1;
    cyc(2);
    chk(sleepOe, 3'h0);
    @(posedge clk_sys) sleepMode <= 1'b0;
    // Turbo and slow speed, source clock
    axiWr(OFF_MISC_SETUP, 32'h133, RESP_OKAY);
    @(posedge clk_sys) turboIn <= 1'b1;
    cyc(6);
    cnt(16);
    chk(sc, 16);
    chk(tc, 4);
    @(posedge clk_sys) turboIn <= 1'b0;
    cyc(6);
    cnt(16);
    chk(sc, 4);
    @(posedge clk_sys) turboIn <= 1'b1;
    axiWr(OFF_MISC_SETUP, 32'h10f, RESP_OKAY);
    cyc(6);
    cnt(32);
    chk(sc, 2);
    chk(tc, 16);
    // Processor reset sources
    @(posedge clk_sys) kbdResetCtrlN <= 1'b0;
    cyc(5);
    chk(procResetOut, 1'b1);
    @(posedge clk_sys) kbdResetCtrlN <= 1'b1;
    cyc(6);
    chk(procResetOut, 1'b0);
    axiWr(OFF_PORT_CTRL, 32'h1, RESP_OKAY);
    cyc(2);
    chk(procResetOut, 1'b1);
    axiWr(OFF_PORT_CTRL, 32'h0, RESP_OKAY);
    @(posedge clk_sys) hwResetIn <= 1'b1;
    cyc(1);
    chk(procResetOut, 1'b1);
    @(posedge clk_sys) hwResetIn <= 1'b0;
    axiRd(OFF_MISC_SETUP, RST_MISC_SETUP, RESP_OKAY);
    tally_and_finish();
  end
endmodule
`default_nettype wire
